// [omd_pkg.sv]
package omd_pkg;
	// internal data space
	localparam int          IDATA_BYTES     = 256;
	localparam int          IDATA_AW        = 8;
	localparam logic [7:0]  IDATA_UPPER     = 8'h80;
	localparam int          SFS_BYTES       = 128;
	localparam logic [7:0]  BANK_END        = 8'h20;
	localparam logic [7:0]  BITSPACE_END    = 8'h30;
	localparam logic [7:0]  BANK_STRIDE     = 8'h08;
	localparam int          BANK_COUNT      = 4;
	// external data block
	localparam int          XRAM_BYTES      = 1024;
	localparam int          XRAM_AW         = 10;
	// program flash
	localparam int          FLASH_BYTES     = 16384;
	localparam int          FLASH_AW        = 14;
	localparam int          SECTOR_AW       = 9;
	localparam int          SECTOR_BYTES    = 512;
	localparam int          SECTOR_COUNT    = 32;
	localparam logic [15:0] FACTORY_LO      = 16'h3e00;
	localparam logic [15:0] FACTORY_HI      = 16'h3fff;
	localparam logic [15:0] EXTRA_BASE      = 16'h8000;
	localparam int          EXTRA_BYTES     = 128;
	localparam int          EXTRA_AW        = 7;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;

	// internal data request from the core
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       indirect;
		logic       bit_op;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} omd_iacc_t;

	// external data request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} omd_xacc_t;

	// code space request; write programs, erase clears a sector or the extra block
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} omd_cacc_t;
endpackage

// [omd_onchip_memory_map_decode.sv]
`timescale 1ns/1ps
module omd_onchip_memory_map_decode
	import omd_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	input  wire omd_iacc_t  i_iacc,
	input  wire logic [1:0] i_bank_sel,
	input  wire logic       i_bank_reg,
	input  wire omd_xacc_t  i_xacc,
	input  wire omd_cacc_t  i_cacc,
	input  wire logic [7:0] i_sfs_rdata,
	output logic            o_sfs_valid,
	output logic            o_sfs_write,
	output logic [6:0]      o_sfs_addr,
	output logic [7:0]      o_sfs_wdata,
	output logic [7:0]      o_idata_rdata,
	output logic            o_idata_rvalid,
	output logic [7:0]      o_xdata_rdata,
	output logic            o_xdata_rvalid,
	output logic [7:0]      o_code_rdata,
	output logic            o_code_rvalid,
	output logic            o_code_factory
);

	////////////////////////////////////////////////////////////////////////
	// decode functions

	// special-function space only on direct access to the upper half
	function automatic logic is_sfs(input logic [7:0] a, input logic ind);
		return a[7] && !ind;
	endfunction

	// bit ops on ram are legal only in the bit-addressable range
	function automatic logic in_bitspace(input logic [7:0] a);
		return (a >= BANK_END) && (a < BITSPACE_END);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0] iram_q [IDATA_BYTES];
	logic [7:0] iram_d [IDATA_BYTES];
	logic [7:0] xram_q [XRAM_BYTES];
	logic [7:0] xram_d [XRAM_BYTES];
	logic [7:0] flash_q [FLASH_BYTES];
	logic [7:0] flash_d [FLASH_BYTES];
	logic [7:0] extra_q [EXTRA_BYTES];
	logic [7:0] extra_d [EXTRA_BYTES];

	logic [7:0] idata_rdata_q, idata_rdata_d;
	logic       idata_rvalid_q, idata_rvalid_d;
	logic       sfs_pend_q, sfs_pend_d;
	logic       sfs_bit_q, sfs_bit_d;
	logic [2:0] sfs_bsel_q, sfs_bsel_d;
	logic [7:0] xdata_rdata_q, xdata_rdata_d;
	logic       xdata_rvalid_q, xdata_rvalid_d;
	logic [7:0] code_rdata_q, code_rdata_d;
	logic       code_rvalid_q, code_rvalid_d;
	logic       code_factory_q, code_factory_d;

	logic [7:0] iaddr;
	logic       isfs;
	logic [7:0] ibyte;

	////////////////////////////////////////////////////////////////////////
	// internal data address: bank registers relocate r0..
	always_comb begin
		iaddr = i_iacc.addr;
		if (i_bank_reg) begin
			iaddr = 8'({i_bank_sel, i_iacc.addr[2:0]});
		end
		isfs  = is_sfs(iaddr, i_iacc.indirect);
		ibyte = iram_q[iaddr];
	end

	// special-function space is forwarded to the core side
	assign o_sfs_valid = i_iacc.valid && isfs && i_ce;
	assign o_sfs_write = i_iacc.write && !i_iacc.bit_op;
	assign o_sfs_addr  = iaddr[6:0];
	assign o_sfs_wdata = i_iacc.wdata;

	// internal ram next state and read data
	always_comb begin
		iram_d         = iram_q;
		idata_rdata_d  = idata_rdata_q;
		idata_rvalid_d = 1'b0;
		sfs_pend_d     = 1'b0;
		sfs_bit_d      = sfs_bit_q;
		sfs_bsel_d     = sfs_bsel_q;
		if (sfs_pend_q) begin
			idata_rvalid_d = 1'b1;
			idata_rdata_d  = sfs_bit_q ?
				{7'h00, i_sfs_rdata[sfs_bsel_q]} : i_sfs_rdata;
		end
		if (i_iacc.valid) begin
			if (isfs) begin
				if (!i_iacc.write) begin
					sfs_pend_d = 1'b1;
					sfs_bit_d  = i_iacc.bit_op;
					sfs_bsel_d = i_iacc.bit_sel;
				end
			end else if (i_iacc.bit_op) begin
				if (in_bitspace(iaddr)) begin
					if (i_iacc.write) begin
						iram_d[iaddr][i_iacc.bit_sel] = i_iacc.wdata[0];
					end else begin
						idata_rvalid_d = 1'b1;
						idata_rdata_d  = {7'h00, ibyte[i_iacc.bit_sel]};
					end
				end
			end else if (i_iacc.write) begin
				iram_d[iaddr] = i_iacc.wdata;
			end else begin
				idata_rvalid_d = 1'b1;
				idata_rdata_d  = ibyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external data ram, aliased across the whole 64k range
	always_comb begin
		xram_d         = xram_q;
		xdata_rdata_d  = xdata_rdata_q;
		xdata_rvalid_d = 1'b0;
		if (i_xacc.valid) begin
			if (i_xacc.write) begin
				xram_d[i_xacc.addr[XRAM_AW-1:0]] = i_xacc.wdata;
			end else begin
				xdata_rvalid_d = 1'b1;
				xdata_rdata_d  = xram_q[i_xacc.addr[XRAM_AW-1:0]];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// code flash: main array, extra block, sector erase
	logic        c_main;
	logic        c_extra;
	logic [13:0] c_off;
	logic [4:0]  c_sec;

	always_comb begin
		c_main  = i_cacc.addr < 16'(FLASH_BYTES);
		c_extra = i_cacc.addr[15:EXTRA_AW] == EXTRA_BASE[15:EXTRA_AW];
		c_off   = i_cacc.addr[FLASH_AW-1:0];
		c_sec   = i_cacc.addr[FLASH_AW-1:SECTOR_AW];
	end

	always_comb begin
		flash_d        = flash_q;
		extra_d        = extra_q;
		code_rdata_d   = code_rdata_q;
		code_rvalid_d  = 1'b0;
		code_factory_d = code_factory_q;
		if (i_cacc.valid) begin
			// flag access inside the factory area
			code_factory_d = (i_cacc.addr >= FACTORY_LO) &&
				(i_cacc.addr <= FACTORY_HI);
			if (i_cacc.erase) begin
				if (c_main) begin
					for (int k = 0; k < SECTOR_BYTES; k++) begin
						flash_d[{c_sec, 9'(k)}] = ERASED_BYTE;
					end
				end else if (c_extra) begin
					for (int k = 0; k < EXTRA_BYTES; k++) begin
						extra_d[k] = ERASED_BYTE;
					end
				end
			end else if (i_cacc.write) begin
				// programming only clears bits, like real flash
				if (c_main) begin
					flash_d[c_off] = flash_q[c_off] & i_cacc.wdata;
				end else if (c_extra) begin
					extra_d[i_cacc.addr[EXTRA_AW-1:0]] =
						extra_q[i_cacc.addr[EXTRA_AW-1:0]] & i_cacc.wdata;
				end
			end else begin
				code_rvalid_d = 1'b1;
				if (c_main) begin
					code_rdata_d = flash_q[c_off];
				end else if (c_extra) begin
					code_rdata_d = extra_q[i_cacc.addr[EXTRA_AW-1:0]];
				end else begin
					code_rdata_d = ERASED_BYTE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers; flash keeps contents through reset
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			for (int k = 0; k < IDATA_BYTES; k++) begin
				iram_q[k] <= RESET_BYTE;
			end
			for (int k = 0; k < XRAM_BYTES; k++) begin
				xram_q[k] <= RESET_BYTE;
			end
			idata_rdata_q  <= RESET_BYTE;
			idata_rvalid_q <= 1'b0;
			sfs_pend_q     <= 1'b0;
			sfs_bit_q      <= 1'b0;
			sfs_bsel_q     <= 3'h0;
			xdata_rdata_q  <= RESET_BYTE;
			xdata_rvalid_q <= 1'b0;
			code_rdata_q   <= RESET_BYTE;
			code_rvalid_q  <= 1'b0;
			code_factory_q <= 1'b0;
		end else if (i_ce) begin
			iram_q         <= iram_d;
			xram_q         <= xram_d;
			idata_rdata_q  <= idata_rdata_d;
			idata_rvalid_q <= idata_rvalid_d;
			sfs_pend_q     <= sfs_pend_d;
			sfs_bit_q      <= sfs_bit_d;
			sfs_bsel_q     <= sfs_bsel_d;
			xdata_rdata_q  <= xdata_rdata_d;
			xdata_rvalid_q <= xdata_rvalid_d;
			code_rdata_q   <= code_rdata_d;
			code_rvalid_q  <= code_rvalid_d;
			code_factory_q <= code_factory_d;
		end
	end

	// flash array: no reset and no initial value; contents are unknown until erased
	always_ff @(posedge i_clk_sys) begin
		if (i_ce) begin
			flash_q <= flash_d;
			extra_q <= extra_d;
		end
	end

	assign o_idata_rdata  = idata_rdata_q;
	assign o_idata_rvalid = idata_rvalid_q;
	assign o_xdata_rdata  = xdata_rdata_q;
	assign o_xdata_rvalid = xdata_rvalid_q;
	assign o_code_rdata   = code_rdata_q;
	assign o_code_rvalid  = code_rvalid_q;
	assign o_code_factory = code_factory_q;

	////////////////////////////////////////////////////////////////////////
	// assertions
	a_sfs_direct: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_iacc.valid && !i_bank_reg && i_iacc.addr[7] &&
		 !i_iacc.indirect) |-> o_sfs_valid)
		else $error("direct upper access not sent to sfs");
	a_indirect_ram: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_iacc.valid && i_iacc.indirect) |-> !o_sfs_valid)
		else $error("indirect access reached sfs");
	a_lower_ram: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_iacc.valid && !i_bank_reg && !i_iacc.addr[7]) |-> !o_sfs_valid)
		else $error("lower half reached sfs");
	a_ram_read_lat: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_iacc.valid && !i_iacc.write && !i_iacc.bit_op && !isfs)
		|=> (!i_ce || o_idata_rvalid) [*1] ##0 (!i_ce || o_idata_rvalid))
		else $error("internal read not answered");
	a_xram_alias: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_xacc.valid && !i_xacc.write)
		|=> (!i_ce || o_xdata_rdata ==
			xram_q[$past(i_xacc.addr[XRAM_AW-1:0])]))
		else $error("external read wrong");
	a_xram_resp: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_xacc.valid && !i_xacc.write) |=> o_xdata_rvalid)
		else $error("external read missing");
	a_factory_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_cacc.valid && i_cacc.addr == FACTORY_LO) |=> o_code_factory)
		else $error("factory area not flagged");
	a_extra_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_cacc.valid && !i_cacc.write && !i_cacc.erase &&
		 i_cacc.addr == EXTRA_BASE) |=> o_code_rdata == extra_q[0])
		else $error("extra block read wrong");
	a_erase_sector: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_cacc.valid && i_cacc.erase && c_main)
		|=> flash_q[{$past(c_sec), 9'h1ff}] == ERASED_BYTE)
		else $error("sector not erased");
	a_main_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && i_cacc.valid && !i_cacc.write && !i_cacc.erase && c_main)
		|=> o_code_rvalid)
		else $error("code read missing");

	c_sfs_read: cover property (@(posedge i_clk_sys)
		o_sfs_valid && !o_sfs_write);
	c_bit_write: cover property (@(posedge i_clk_sys)
		i_iacc.valid && i_iacc.bit_op && i_iacc.write);
	c_xram_high: cover property (@(posedge i_clk_sys)
		i_xacc.valid && i_xacc.addr[15]);
	c_erase: cover property (@(posedge i_clk_sys)
		i_cacc.valid && i_cacc.erase);

endmodule

// [omd_sfs_model.sv]
`timescale 1ns/1ps
// stand-in for the special-function space behind the decoder
module omd_sfs_model
	import omd_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_valid,
	input  wire logic       i_write,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic [7:0]      o_rdata
);
	logic [7:0] mem [SFS_BYTES];
	logic [6:0] addr_q;
	logic       pend_q;

	// known contents so a direct read is told apart from ram
	initial begin
		for (int i = 0; i < SFS_BYTES; i++) begin
			mem[i] = 8'h5a ^ 8'(i);
		end
		pend_q = 1'b0;
		addr_q = '0;
	end

	// take the forwarded access; writes land at once
	always @(posedge i_clk_sys) begin
		pend_q <= i_valid && !i_write;
		addr_q <= i_addr;
		if (i_valid && i_write) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// outside the answer cycle show a scrambled value, never the last one
	assign o_rdata = pend_q ? mem[addr_q] : ~mem[addr_q];
endmodule

// [omd_onchip_memory_map_decode_tb.sv]
`timescale 1ns/1ps
module omd_onchip_memory_map_decode_tb
	import omd_pkg::*;
;
	logic       i_clk_sys, i_rst, i_ce, i_bank_reg;
	logic [1:0] i_bank_sel;
	omd_iacc_t  i_iacc;
	omd_xacc_t  i_xacc;
	omd_cacc_t  i_cacc;
	logic [7:0] sfs_rdata, sfs_wdata, i_rd, x_rd, c_rd;
	logic [6:0] sfs_addr;
	logic       sfs_valid, sfs_write, i_rv, x_rv, c_rv, c_fac;
	int         num_errors, num_checks, cycles;

	////////////////////////////////////////////////////////////////////////
	// clock, timeout and instances
	initial i_clk_sys = 1'b0;
	always #2 i_clk_sys = ~i_clk_sys;
	initial cycles = 0;
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			print_verdict();
		end
	end

	omd_onchip_memory_map_decode omd_onchip_memory_map_decode_inst (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_iacc(i_iacc),
		.i_bank_sel(i_bank_sel), .i_bank_reg(i_bank_reg), .i_xacc(i_xacc),
		.i_cacc(i_cacc), .i_sfs_rdata(sfs_rdata), .o_sfs_valid(sfs_valid),
		.o_sfs_write(sfs_write), .o_sfs_addr(sfs_addr),
		.o_sfs_wdata(sfs_wdata), .o_idata_rdata(i_rd),
		.o_idata_rvalid(i_rv), .o_xdata_rdata(x_rd), .o_xdata_rvalid(x_rv),
		.o_code_rdata(c_rd), .o_code_rvalid(c_rv), .o_code_factory(c_fac));

	omd_sfs_model omd_sfs_model_inst (
		.i_clk_sys(i_clk_sys), .i_valid(sfs_valid), .i_write(sfs_write),
		.i_addr(sfs_addr), .i_wdata(sfs_wdata), .o_rdata(sfs_rdata));

	////////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// bus cycles: drive at the falling edge, one request, then idle
	task automatic iop(input logic w, ind, bo, input logic [2:0] bs,
		input logic [7:0] a, d, input bit slow);
		@(negedge i_clk_sys);
		i_iacc = {1'b1, w, ind, bo, bs, a, d};
		@(negedge i_clk_sys);
		i_iacc.valid = 1'b0;
		if (slow) @(negedge i_clk_sys);
	endtask

	// read; a direct upper read answers one cycle later
	task automatic ird(input logic ind, bo, input logic [2:0] bs,
		input logic [7:0] a, exp);
		iop(1'b0, ind, bo, bs, a, 8'h00, !ind && a >= IDATA_UPPER);
		chk({7'h00, i_rv}, 8'h01);
		chk(i_rd, exp);
	endtask

	task automatic xop(input logic w, input logic [15:0] a,
		input logic [7:0] d, exp);
		@(negedge i_clk_sys);
		i_xacc = {1'b1, w, a, d};
		@(negedge i_clk_sys);
		i_xacc.valid = 1'b0;
		if (!w) chk({7'h00, x_rv}, 8'h01);
		if (!w) chk(x_rd, exp);
	endtask

	task automatic cop(input logic w, e, input logic [15:0] a,
		input logic [7:0] d, exp, input logic fac);
		@(negedge i_clk_sys);
		i_cacc = {1'b1, w, e, a, d};
		@(negedge i_clk_sys);
		i_cacc.valid = 1'b0;
		if (!w && !e) chk({6'h00, c_rv, c_fac}, {7'h01, fac});
		if (!w && !e) chk(c_rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_lower();
		iop(1'b1, 1'b0, 1'b0, 3'h0, 8'h45, 8'h96, 0);
		ird(1'b1, 1'b0, 3'h0, 8'h45, 8'h96);
		ird(1'b1, 1'b0, 3'h0, 8'h7f, 8'h00);
		i_bank_sel = 2'h3;
		i_bank_reg = 1'b1;
		iop(1'b1, 1'b0, 1'b0, 3'h0, 8'h07, 8'h77, 0);
		i_bank_reg = 1'b0;
		ird(1'b1, 1'b0, 3'h0, 8'h1f, 8'h77);
		ird(1'b0, 1'b0, 3'h0, 8'h07, 8'h00);
		$display("test lower done");
	endtask

	task automatic t_upper();
		iop(1'b1, 1'b1, 1'b0, 3'h0, 8'h90, 8'h3c, 0);
		ird(1'b1, 1'b0, 3'h0, 8'h90, 8'h3c);
		ird(1'b0, 1'b0, 3'h0, 8'h90, 8'h4a);
		ird(1'b0, 1'b1, 3'h1, 8'h90, 8'h01);
		iop(1'b1, 1'b0, 1'b0, 3'h0, 8'hff, 8'hc3, 0);
		ird(1'b0, 1'b0, 3'h0, 8'hff, 8'hc3);
		ird(1'b1, 1'b0, 3'h0, 8'hff, 8'h00);
		$display("test upper done");
	endtask

	task automatic t_bits();
		iop(1'b1, 1'b0, 1'b0, 3'h0, 8'h2f, 8'h00, 0);
		iop(1'b1, 1'b0, 1'b1, 3'h5, 8'h2f, 8'h01, 0);
		ird(1'b0, 1'b0, 3'h0, 8'h2f, 8'h20);
		ird(1'b0, 1'b1, 3'h5, 8'h2f, 8'h01);
		ird(1'b0, 1'b1, 3'h4, 8'h2f, 8'h00);
		iop(1'b0, 1'b0, 1'b1, 3'h0, 8'h30, 8'h00, 0);
		chk({7'h00, i_rv}, 8'h00);
		$display("test bits done");
	endtask

	// clock enable low: a write and a read are both ignored
	task automatic t_ce();
		@(negedge i_clk_sys);
		i_ce = 1'b0;
		iop(1'b1, 1'b1, 1'b0, 3'h0, 8'h45, 8'h11, 0);
		iop(1'b0, 1'b1, 1'b0, 3'h0, 8'h45, 8'h00, 0);
		chk({7'h00, i_rv}, 8'h00);
		i_ce = 1'b1;
		ird(1'b1, 1'b0, 3'h0, 8'h45, 8'h96);
		$display("test ce done");
	endtask

	// mid-run reset clears data ram but keeps flash
	task automatic t_reset();
		@(negedge i_clk_sys);
		i_rst = 1'b1;
		repeat (2) @(negedge i_clk_sys);
		i_rst = 1'b0;
		ird(1'b1, 1'b0, 3'h0, 8'h45, 8'h00);
		cop(1'b0, 1'b0, 16'h0210, 8'h00, 8'h5a, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_xram();
		xop(1'b1, 16'h0123, 8'hab, 8'h00);
		xop(1'b0, 16'hfd23, 8'h00, 8'hab);
		xop(1'b1, 16'hffff, 8'h5e, 8'h00);
		xop(1'b0, 16'h03ff, 8'h00, 8'h5e);
		xop(1'b0, 16'h0400, 8'h00, 8'h00);
		$display("test xram done");
	endtask

	task automatic t_code();
		cop(1'b0, 1'b1, 16'h03ff, 8'h00, 8'h00, 1'b0);
		cop(1'b0, 1'b0, 16'h0200, 8'h00, 8'hff, 1'b0);
		cop(1'b1, 1'b0, 16'h0210, 8'h5a, 8'h00, 1'b0);
		cop(1'b0, 1'b0, 16'h0210, 8'h00, 8'h5a, 1'b0);
		cop(1'b0, 1'b1, 16'h8000, 8'h00, 8'h00, 1'b0);
		cop(1'b0, 1'b0, 16'h8000, 8'h00, 8'hff, 1'b0);
		cop(1'b1, 1'b0, 16'h807f, 8'h12, 8'h00, 1'b0);
		cop(1'b0, 1'b0, 16'h807f, 8'h00, 8'h12, 1'b0);
		cop(1'b0, 1'b0, 16'h8080, 8'h00, 8'hff, 1'b0);
		cop(1'b0, 1'b1, 16'h3c00, 8'h00, 8'h00, 1'b0);
		cop(1'b0, 1'b1, 16'h3e00, 8'h00, 8'h00, 1'b0);
		cop(1'b0, 1'b0, 16'h3fff, 8'h00, 8'hff, 1'b1);
		cop(1'b0, 1'b0, 16'h3dff, 8'h00, 8'hff, 1'b0);
		$display("test code done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		num_errors = 0;
		num_checks = 0;
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_bank_sel = 2'h0;
		i_bank_reg = 1'b0;
		i_iacc = '0;
		i_xacc = '0;
		i_cacc = '0;
		repeat (5) @(negedge i_clk_sys);
		i_rst = 1'b0;
		t_lower();
		t_upper();
		t_bits();
		t_ce();
		t_xram();
		t_code();
		t_reset();
		print_verdict();
	end
endmodule
